// ===== src/pisp_pkg.sv
package pisp_pkg;

  // ==========================================================================
  // Register bus geometry
  // ==========================================================================
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  typedef logic [ADDR_W-1:0] pisp_addr_t;
  typedef logic [DATA_W-1:0] pisp_data_t;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam pisp_addr_t OFF_IRQ_TEST_POLARITY     = 16'h0011;
  localparam pisp_addr_t OFF_IRQ_STATUS_ENABLE_ONE = 16'h0012;
  localparam pisp_addr_t OFF_FALSE_CARRIER_COUNTER = 16'h0014;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam pisp_data_t RST_IRQ_TEST_POLARITY     = 16'h010B;
  localparam pisp_data_t RST_IRQ_STATUS_ENABLE_ONE = 16'h0000;
  localparam pisp_data_t READ_ZERO                 = 16'h0000;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned TEST_POLARITY_BIT = 3;
  localparam int unsigned TEST_FORCE_BIT    = 2;
  localparam int unsigned NUM_SOURCES       = 8;
  localparam int unsigned STATUS_LSB        = 8;
  localparam int unsigned ENABLE_LSB        = 0;

  // Source index inside the 8-bit event vector; bit 7 maps to status bit 15.
  localparam int unsigned SRC_LINK_QUALITY  = 7;
  localparam int unsigned SRC_ENERGY        = 6;
  localparam int unsigned SRC_LINK_STATUS   = 5;
  localparam int unsigned SRC_WAKE_FRAME    = 4;
  localparam int unsigned SRC_ESD           = 3;
  localparam int unsigned SRC_MASTER_SLAVE_TRAINING   = 2;
  localparam int unsigned SRC_FC_HALF_FULL  = 1;
  localparam int unsigned SRC_RX_HALF_FULL  = 0;

  // ==========================================================================
  // False carrier counter
  // ==========================================================================
  localparam int unsigned FC_W = 8;

  typedef logic [FC_W-1:0] pisp_count_t;

  localparam pisp_count_t FC_ZERO      = 8'h00;
  localparam pisp_count_t FC_ONE       = 8'h01;
  localparam pisp_count_t FC_HALF_FULL = 8'h7F;
  localparam pisp_count_t FC_MAX       = 8'hFF;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  // Indications from the PHY core; pulses are one clock wide.
  typedef struct packed {
    logic link_quality_change;  // Pulse: link quality moved.
    logic link_up;              // Level: link status.
    logic energy_detected;      // Level: energy seen on the line.
    logic wake_frame;           // Pulse: wake frame recognised.
    logic esd_event;            // Pulse: discharge event sensed.
    logic master_slave_training;// Pulse: training finished.
    logic false_carrier;        // Pulse: one false carrier event.
    logic receive_error_half_full; // Pulse: receive error counter passed half.
  } pisp_events_s;

  // Register bus request.
  typedef struct packed {
    pisp_addr_t addr;
    pisp_data_t wr_data;
    logic       wr_en;
    logic       rd_en;
  } pisp_bus_req_s;

endpackage

// ===== src/pisp_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none

module pisp_sat_counter (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  incr,
  input  wire logic                  clear,
  output var  pisp_pkg::pisp_count_t count,
  output var  logic                  half_full_pulse
);
  import pisp_pkg::*;

  pisp_count_t count_reg;
  pisp_count_t count_next;
  logic        pulse_reg;
  logic        pulse_next;

  // ==========================================================================
  // Counting
  // ==========================================================================
  // A clear by read wins over stored history, but an event in the same
  // cycle is still counted so that no false carrier goes unseen.
  always_comb begin
    count_next = count_reg;
    pulse_next = 1'b0;
    if (clear) begin
      count_next = incr ? FC_ONE : FC_ZERO;
    end else if (incr && (count_reg != FC_MAX)) begin
      count_next = count_reg + FC_ONE;
      pulse_next = (count_reg == FC_HALF_FULL);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= FC_ZERO;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign count           = count_reg;
  assign half_full_pulse = pulse_reg;

endmodule

`default_nettype wire

// ===== src/pisp_irq_top.sv
`timescale 1ns/1ps
`default_nettype none

module pisp_irq_top (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire pisp_pkg::pisp_events_s events,
  input  wire pisp_pkg::pisp_addr_t   addr,
  input  wire pisp_pkg::pisp_data_t   wr_data,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output var  pisp_pkg::pisp_data_t   rd_data,
  output var  logic                   irq_pin,
  output var  logic                   irq_active
);
  import pisp_pkg::*;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  // One address comparison shared by the read path and the write path.
  function automatic logic addr_hit(input pisp_addr_t a, input pisp_addr_t off);
    addr_hit = (a == off);
  endfunction

  logic hit_test;
  logic hit_status;
  logic hit_fc;

  assign hit_test   = addr_hit(addr, OFF_IRQ_TEST_POLARITY);
  assign hit_status = addr_hit(addr, OFF_IRQ_STATUS_ENABLE_ONE);
  assign hit_fc     = addr_hit(addr, OFF_FALSE_CARRIER_COUNTER);

  // ==========================================================================
  // False carrier counter
  // ==========================================================================
  pisp_count_t fc_count;
  logic        fc_half_full;

  pisp_sat_counter u_fc_counter (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .incr            (events.false_carrier),
    .clear           (rd_en && hit_fc),
    .count           (fc_count),
    .half_full_pulse (fc_half_full)
  );

  // ==========================================================================
  // Level history for change detection
  // ==========================================================================
  logic link_up_reg;
  logic link_up_next;
  logic energy_reg;
  logic energy_next;

  // Levels are remembered so that a change in either direction is an event.
  // The history starts at zero, so a level high out of reset counts once.
  always_comb begin
    link_up_next = events.link_up;
    energy_next  = events.energy_detected;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_up_reg <= 1'b0;
      energy_reg  <= 1'b0;
    end else begin
      link_up_reg <= link_up_next;
      energy_reg  <= energy_next;
    end
  end

  // ==========================================================================
  // Event vector
  // ==========================================================================
  logic [NUM_SOURCES-1:0] src_event;

  // Each source gets its own slot; bit 7 lands in status bit 15.
  always_comb begin
    src_event = '0;
    src_event[SRC_LINK_QUALITY] = events.link_quality_change && events.link_up;
    src_event[SRC_ENERGY]       = events.energy_detected != energy_reg;
    src_event[SRC_LINK_STATUS]  = events.link_up != link_up_reg;
    src_event[SRC_WAKE_FRAME]   = events.wake_frame;
    src_event[SRC_ESD]          = events.esd_event;
    src_event[SRC_MASTER_SLAVE_TRAINING]  = events.master_slave_training;
    src_event[SRC_FC_HALF_FULL] = fc_half_full;
    src_event[SRC_RX_HALF_FULL] = events.receive_error_half_full;
  end

  // ==========================================================================
  // Status and enable register
  // ==========================================================================
  logic [NUM_SOURCES-1:0] status_reg;
  logic [NUM_SOURCES-1:0] status_next;
  logic [NUM_SOURCES-1:0] enable_reg;
  logic [NUM_SOURCES-1:0] enable_next;
  logic                   status_read;

  assign status_read = rd_en && hit_status;

  // Sticky bits: a read clears them, but an event in the same cycle sets
  // the bit again so that it is never lost between read and clear.
  generate
    for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_latch
      always_comb begin
        status_next[i] = status_reg[i];
        if (status_read) begin
          status_next[i] = 1'b0;
        end
        if (src_event[i]) begin
          status_next[i] = 1'b1;
        end
      end
    end
  endgenerate

  // Only the low byte is writable; the status byte ignores writes.
  always_comb begin
    enable_next = enable_reg;
    if (wr_en && hit_status) begin
      enable_next = wr_data[ENABLE_LSB +: NUM_SOURCES];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_reg <= RST_IRQ_STATUS_ENABLE_ONE[STATUS_LSB +: NUM_SOURCES];
      enable_reg <= RST_IRQ_STATUS_ENABLE_ONE[ENABLE_LSB +: NUM_SOURCES];
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  // ==========================================================================
  // Test and polarity register
  // ==========================================================================
  pisp_data_t test_reg;
  pisp_data_t test_next;

  // Reserved fields are stored as written, so software that writes them
  // back unchanged keeps the reset pattern in place.
  always_comb begin
    test_next = test_reg;
    if (wr_en && hit_test) begin
      test_next = wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      test_reg <= RST_IRQ_TEST_POLARITY;
    end else begin
      test_reg <= test_next;
    end
  end

  // ==========================================================================
  // Interrupt pin
  // ==========================================================================
  logic irq_level;
  logic pin_next;
  logic irq_pin_reg;
  logic irq_active_reg;

  // The pin is registered so that no glitch from the OR tree reaches the
  // host; this costs one cycle of latency after the event is latched.
  always_comb begin
    irq_level = (|(status_reg & enable_reg))
              || test_reg[TEST_FORCE_BIT];
    pin_next  = test_reg[TEST_POLARITY_BIT] ? !irq_level : irq_level;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_pin_reg    <= RST_IRQ_TEST_POLARITY[TEST_POLARITY_BIT];
      irq_active_reg <= 1'b0;
    end else begin
      irq_pin_reg    <= pin_next;
      irq_active_reg <= irq_level;
    end
  end

  assign irq_pin    = irq_pin_reg;
  assign irq_active = irq_active_reg;

  // ==========================================================================
  // Read path
  // ==========================================================================
  pisp_data_t rd_data_reg;
  pisp_data_t rd_data_next;

  // Data stand only in the cycle after the read strobe; otherwise zero.
  // Unmapped addresses read as zero.
  always_comb begin
    rd_data_next = READ_ZERO;
    if (rd_en) begin
      if (hit_test) begin
        rd_data_next = test_reg;
      end else if (hit_status) begin
        rd_data_next = {status_reg, enable_reg};
      end else if (hit_fc) begin
        rd_data_next = {{(DATA_W-FC_W){1'b0}}, fc_count};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data_reg <= READ_ZERO;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data = rd_data_reg;

endmodule

`default_nettype wire

// ===== verif/pisp_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module pisp_irq_asserts (
  input wire logic                   clock,
  input wire logic                   sys_rst,
  input wire pisp_pkg::pisp_events_s events,
  input wire pisp_pkg::pisp_addr_t   addr,
  input wire pisp_pkg::pisp_data_t   wr_data,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire pisp_pkg::pisp_data_t   rd_data,
  input wire logic                   irq_pin,
  input wire logic                   irq_active
);
  import pisp_pkg::*;
  logic [7:0] en_q;
  logic       pol_q;
  logic       frc_q;
  wire logic  st_rd = rd_en && addr == OFF_IRQ_STATUS_ENABLE_ONE;
  wire logic  ts_rd = rd_en && addr == OFF_IRQ_TEST_POLARITY;
  wire logic  st_wr = wr_en && addr == OFF_IRQ_STATUS_ENABLE_ONE;
  wire logic  ts_wr = wr_en && addr == OFF_IRQ_TEST_POLARITY;

  // ========
  // Shadow of the control bits, rebuilt from bus writes so no hierarchy is needed.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_q  <= 8'h00;
      pol_q <= 1'b1;
      frc_q <= 1'b0;
    end else if (st_wr) begin
      en_q <= wr_data[7:0];
    end else if (ts_wr) begin
      pol_q <= wr_data[3];
      frc_q <= wr_data[2];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ========
  // Pin level, forcing, source and read-back checks.
  chk_rst_idle: assert property (
    disable iff (1'b0) sys_rst |=> irq_pin && !irq_active)
    else $error("pin not idle after reset");
  chk_pin_level: assert property (
    pol_q == $past(pol_q) |-> irq_pin == (irq_active ^ pol_q))
    else $error("pin level disagrees with polarity");
  chk_force_on: assert property (frc_q |=> irq_active)
    else $error("forced interrupt missing");
  chk_force_off: assert property (
    $fell(frc_q) && en_q == 8'h00 |=> !irq_active)
    else $error("interrupt stays after force cleared");
  chk_esd_irq: assert property (
    events.esd_event ##1 en_q[3] |=> irq_active)
    else $error("enabled discharge event gave no interrupt");
  chk_esd_latch: assert property (
    events.esd_event ##1 st_rd |=> rd_data[11])
    else $error("discharge status bit not latched");
  chk_enable_rd: assert property (
    st_rd |=> rd_data[7:0] == $past(en_q))
    else $error("enable bits read back wrong");
  chk_test_rd: assert property (
    ts_rd |=> rd_data[3] == $past(pol_q) && rd_data[2] == $past(frc_q))
    else $error("test bits read back wrong");

  cover property (frc_q ##2 irq_active);
  cover property (events.esd_event ##1 en_q[3]);
  cover property (st_rd ##1 rd_data[9]);
endmodule

bind pisp_irq_top pisp_irq_asserts i_pisp_irq_asserts (
  .clock      (clock),
  .sys_rst    (sys_rst),
  .events     (events),
  .addr       (addr),
  .wr_data    (wr_data),
  .wr_en      (wr_en),
  .rd_en      (rd_en),
  .rd_data    (rd_data),
  .irq_pin    (irq_pin),
  .irq_active (irq_active)
);

`default_nettype wire

// ===== verif/pisp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pisp_host_model (
  input  wire logic clock,
  input  wire logic irq_pin,
  input  wire logic pol,
  output var  logic irq_seen
);
  // ========
  // Host input flop; it undoes the programmed pin polarity and, being a flop, lags the pin by a cycle.
  always_ff @(posedge clock) begin
    irq_seen <= irq_pin ^ pol;
  end
endmodule

`default_nettype wire

// ===== verif/pisp_irq_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module pisp_irq_top_tb_top;
  import pisp_pkg::*;
  logic         clock;
  logic         sys_rst;
  pisp_events_s events;
  pisp_addr_t   addr;
  pisp_data_t   wr_data;
  logic         wr_en;
  logic         rd_en;
  pisp_data_t   rd_data;
  logic         irq_pin;
  logic         irq_active;
  logic         host_pol;
  logic         irq_seen;
  int           err_total = 0;
  int           tests_run = 0;
  int           cyc = 0;

  pisp_irq_top i_pisp_irq_top (.clock(clock), .sys_rst(sys_rst), .events(events),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .irq_pin(irq_pin), .irq_active(irq_active));
  pisp_host_model i_pisp_host_model (.clock(clock), .irq_pin(irq_pin), .pol(host_pol),
    .irq_seen(irq_seen));

  // ========
  // Comparison and bus helpers.
  task automatic cmp_w(input pisp_data_t got, input pisp_data_t exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, input logic exp);
    cmp_w({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input pisp_addr_t a, input pisp_data_t d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input pisp_addr_t a, input pisp_data_t exp);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    cmp_w(rd_data, exp);
  endtask
  // The pin is judged both directly and through the host's view of it.
  task automatic chk_irq(input logic on);
    cmp_b(irq_active, on);
    cmp_b(irq_pin, on ^ host_pol);
    cmp_b(irq_seen, on);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      events <= pisp_events_s'(8'h42);
      @(posedge clock);
      events <= pisp_events_s'(8'h40);
    end
  endtask

  // ========
  // Scenarios.
  task automatic t_reset();
    rd(OFF_IRQ_TEST_POLARITY, RST_IRQ_TEST_POLARITY);
    wr(OFF_IRQ_STATUS_ENABLE_ONE, 16'hFF00);
    rd(OFF_IRQ_STATUS_ENABLE_ONE, RST_IRQ_STATUS_ENABLE_ONE);
    wr(16'h0013, 16'hFFFF);
    rd(16'h0013, READ_ZERO);
    rd(OFF_FALSE_CARRIER_COUNTER, 16'h0000);
    chk_irq(1'b0);
  endtask
  // A discharge event read back in the very next cycle must already be latched.
  task automatic t_esd_read();
    wr(OFF_IRQ_STATUS_ENABLE_ONE, 16'h0000);
    @(posedge clock);
    events <= pisp_events_s'(8'h48);
    @(posedge clock);
    events <= pisp_events_s'(8'h40);
    addr   <= OFF_IRQ_STATUS_ENABLE_ONE;
    rd_en  <= 1'b1;
    @(posedge clock);
    rd_en  <= 1'b0;
    #1;
    cmp_w(rd_data, 16'h0800);
    rd(OFF_IRQ_STATUS_ENABLE_ONE, 16'h0000);
  endtask
  // Enable one source or none, raise its event, then read to clear the latched bit.
  task automatic t_src(input int s, input logic [7:0] p, l, input logic en);
    pisp_data_t ew;
    ew = {8'h00, en ? 8'(1 << s) : 8'h00};
    wr(OFF_IRQ_STATUS_ENABLE_ONE, ew);
    @(posedge clock);
    events <= pisp_events_s'(p | l);
    @(posedge clock);
    events <= pisp_events_s'(l);
    tick(3);
    chk_irq(en);
    rd(OFF_IRQ_STATUS_ENABLE_ONE, ew | pisp_data_t'(1 << (s + 8)));
    tick(2);
    chk_irq(1'b0);
    rd(OFF_IRQ_STATUS_ENABLE_ONE, ew);
  endtask
  task automatic t_fc();
    wr(OFF_IRQ_STATUS_ENABLE_ONE, 16'h0002);
    pulses(127);
    tick(3);
    chk_irq(1'b0);
    pulses(1);
    tick(4);
    chk_irq(1'b1);
    rd(OFF_FALSE_CARRIER_COUNTER, 16'h0080);
    rd(OFF_IRQ_STATUS_ENABLE_ONE, 16'h0202);
    pulses(260);
    rd(OFF_FALSE_CARRIER_COUNTER, 16'h00FF);
    rd(OFF_IRQ_STATUS_ENABLE_ONE, 16'h0202);
  endtask
  // Reserved test bits are always written back at their reset values.
  task automatic t_force();
    wr(OFF_IRQ_STATUS_ENABLE_ONE, 16'h0000);
    wr(OFF_IRQ_TEST_POLARITY, 16'h010F);
    tick(20);
    chk_irq(1'b1);
    rd(OFF_IRQ_TEST_POLARITY, 16'h010F);
    wr(OFF_IRQ_TEST_POLARITY, 16'h0107);
    host_pol <= 1'b0;
    tick(3);
    chk_irq(1'b1);
    wr(OFF_IRQ_TEST_POLARITY, 16'h0103);
    tick(3);
    chk_irq(1'b0);
    wr(OFF_IRQ_TEST_POLARITY, 16'h010B);
    host_pol <= 1'b1;
    tick(3);
    chk_irq(1'b0);
  endtask

  task automatic close_out();
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ========
  // Clock, hang guard and main sequence.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    sys_rst  = 1'b1;
    events   = '0;
    addr     = '0;
    wr_data  = '0;
    wr_en    = 1'b0;
    rd_en    = 1'b0;
    host_pol = 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_src(5, 8'h00, 8'h40, 1'b1);
    t_src(7, 8'h80, 8'h40, 1'b1);
    t_src(6, 8'h00, 8'h60, 1'b1);
    t_src(6, 8'h00, 8'h40, 1'b1);
    t_src(4, 8'h10, 8'h40, 1'b1);
    t_src(3, 8'h08, 8'h40, 1'b0);
    t_src(3, 8'h08, 8'h40, 1'b1);
    t_esd_read();
    t_src(2, 8'h04, 8'h40, 1'b1);
    t_src(0, 8'h01, 8'h40, 1'b1);
    t_fc();
    t_src(5, 8'h00, 8'h00, 1'b1);
    t_force();
    close_out();
  end
endmodule

`default_nettype wire
